/* File: hw/gdpin_pkg.sv */
/*
 * Package for the gate driver pin control block: state encodings, carrier
 * structs and synchroniser depth.
 * Assumes a single core clock; no software-visible registers.
 */
package gdpin_pkg;

   // ----------------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------------
   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned SYNC_MSB    = SYNC_STAGES - 1;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      GDPIN_ST_RESET = 2'b00,
      GDPIN_ST_OFF   = 2'b01,
      GDPIN_ST_ON    = 2'b10
   } gdpin_state_t;

   // Event inputs from internal monitors, same clock domain
   typedef struct packed {
      logic fail_class_a;
      logic fail_class_b;
      logic reset_event;
      logic primary_ok;
      logic sec_supply_lockout;
      logic vreg_invalid;
      logic gate_below_clamp;
   } gdpin_mon_t;

   // Gate output stage controls
   typedef struct packed {
      logic on_drive;
      logic on_oe;
      logic off_drive;
      logic off_oe;
   } gdpin_stage_t;

endpackage

/* File: hw/gdpin_ctrl.sv */
/*
 * Pin control and fault notification logic of an isolated gate driver.
 * Assumes monitor inputs are on core_clk; pins (enable, reset, disable,
 * strap) are asynchronous and synchronised here; serial select is used unsynchronised.
 */
`timescale 1ns/1ps

// Function
// - Class A failure pulls fault A low
// - Class B or reset pulls fault B low
// - Low reset pin returns logic to default
// - Reset pin released high only when functional
// - Debug strap sampled once after power-up
// - Latched strap selects serial-free development mode
// - Disable input tristates turn-on/turn-off outputs
// - Enable evaluated as level, low turns off
// - Supply-bad pin low on lockout or invalid
// - Clamp enable high when gate below threshold and state not ON
// - Serial inputs ignored, output tristate when deselected
module gdpin_ctrl
   import gdpin_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic         enable_in,
   input  wire logic         pwm_cmd,
   input  wire logic         output_stage_disable_in,
   input  wire logic         debug_strap_in,
   input  wire logic         reset_ready_pin_i,
   output logic              reset_ready_pin_o,
   output logic              reset_ready_pin_oe,
   output logic              fault_a_out_o,
   output logic              fault_a_out_oe,
   output logic              fault_b_out_o,
   output logic              fault_b_out_oe,
   output logic              secondary_supply_bad_out_o,
   output logic              secondary_supply_bad_out_oe,
   input  wire gdpin_mon_t   mon,
   output logic              miller_clamp_enable_out,
   output gdpin_stage_t      stage,
   output logic              debug_mode,
   input  wire logic         serial_select_low,
   input  wire logic         serial_clk_in,
   input  wire logic         serial_data_in,
   input  wire logic         serial_data_tx,
   output logic              serial_clk_gated,
   output logic              serial_data_gated,
   output logic              serial_data_out_o,
   output logic              serial_data_out_oe,
   output gdpin_state_t      state
);

   // ----------------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------------
   logic [SYNC_MSB:0] en_sync_q;
   logic [SYNC_MSB:0] rst_sync_q;
   logic [SYNC_MSB:0] dis_sync_q;
   logic [SYNC_MSB:0] dbg_sync_q;
   logic              en_q;
   logic              rst_low_q;
   logic              dis_q;

   function automatic logic agree_val(input logic [SYNC_MSB:0] s, input logic prev);
      agree_val = (s[SYNC_MSB] == s[SYNC_MSB-1]) ? s[SYNC_MSB] : prev;
   endfunction

   // A lone odd sample never fills two stages at once, so one-cycle glitches
   // are dropped. The reset pin idles high, hence its chain resets to ones:
   // anything else would fake a pin reset right after power-up.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_sync_q  <= '0;
         rst_sync_q <= '1;
         dis_sync_q <= '0;
         dbg_sync_q <= '0;
      end else begin
         en_sync_q  <= {en_sync_q[SYNC_MSB-1:0], enable_in};
         rst_sync_q <= {rst_sync_q[SYNC_MSB-1:0], reset_ready_pin_i};
         dis_sync_q <= {dis_sync_q[SYNC_MSB-1:0], output_stage_disable_in};
         dbg_sync_q <= {dbg_sync_q[SYNC_MSB-1:0], debug_strap_in};
      end
   end

   // Change accepted only once last two stages agree
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_q      <= 1'b0;
         rst_low_q <= 1'b0;
         dis_q     <= 1'b0;
      end else begin
         en_q      <= agree_val(en_sync_q, en_q);
         rst_low_q <= ~agree_val(rst_sync_q, ~rst_low_q);
         dis_q     <= agree_val(dis_sync_q, dis_q);
      end
   end

   // ----------------------------------------------------------------------
   // Debug strap capture
   // ----------------------------------------------------------------------
   // Taken once after power-up when the synchroniser has filled; later
   // pin changes and pin resets do not retake it.
   logic [SYNC_MSB:0] dbg_wait_q;
   logic              dbg_done_q;
   logic              debug_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dbg_wait_q <= '0;
         dbg_done_q <= 1'b0;
         debug_q    <= 1'b0;
      end else if (!dbg_done_q) begin
         dbg_wait_q <= {dbg_wait_q[SYNC_MSB-1:0], 1'b1};
         if (dbg_wait_q[SYNC_MSB] && dbg_sync_q[SYNC_MSB] == dbg_sync_q[SYNC_MSB-1]) begin
            dbg_done_q <= 1'b1;
            debug_q    <= dbg_sync_q[SYNC_MSB];
         end
      end
   end

   assign debug_mode = debug_q;

   // ----------------------------------------------------------------------
   // Control state
   // ----------------------------------------------------------------------
   gdpin_state_t state_q;

   // A pin reset overrides every state; the walk resumes through OFF.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= GDPIN_ST_RESET;
      end else if (rst_low_q) begin
         state_q <= GDPIN_ST_RESET;
      end else begin
         case (state_q)
            GDPIN_ST_RESET: state_q <= GDPIN_ST_OFF;
            GDPIN_ST_OFF:   if (en_q && pwm_cmd) state_q <= GDPIN_ST_ON;
            GDPIN_ST_ON:    if (!en_q || !pwm_cmd) state_q <= GDPIN_ST_OFF;
            default:        state_q <= GDPIN_ST_RESET;
         endcase
      end
   end

   assign state = state_q;

   // ----------------------------------------------------------------------
   // Output stage and clamp
   // ----------------------------------------------------------------------
   logic         clamp_q;
   gdpin_stage_t stage_q;

   // Enables follow the disable pin alone, so a tristate request beats any drive.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stage_q <= '0;
      end else begin
         stage_q.on_drive  <= (state_q == GDPIN_ST_ON);
         stage_q.off_drive <= (state_q != GDPIN_ST_ON);
         stage_q.on_oe     <= ~dis_q;
         stage_q.off_oe    <= ~dis_q;
      end
   end

   // Not ON stands for turn-off; the clamp lets go as soon as turn-on starts.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clamp_q <= 1'b0;
      end else begin
         clamp_q <= (state_q != GDPIN_ST_ON) && mon.gate_below_clamp;
      end
   end

   assign stage                   = stage_q;
   assign miller_clamp_enable_out = clamp_q;

   // ----------------------------------------------------------------------
   // Open-drain notifications
   // ----------------------------------------------------------------------
   logic flt_a_q;
   logic flt_b_q;
   logic uv_q;
   logic rdy_q;

   // Ready follows primary health only. Pulling the line during a pin reset
   // would read back as a fresh reset once released, and the device would
   // cycle through reset on its own. Rstn still holds the line low.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flt_a_q <= 1'b0;
         flt_b_q <= 1'b1;
         uv_q    <= 1'b1;
         rdy_q   <= 1'b0;
      end else begin
         flt_a_q <= mon.fail_class_a;
         flt_b_q <= mon.fail_class_b | mon.reset_event | rst_low_q;
         uv_q    <= mon.sec_supply_lockout | mon.vreg_invalid;
         rdy_q   <= mon.primary_ok;
      end
   end

   assign fault_a_out_o               = 1'b0;
   assign fault_a_out_oe              = flt_a_q;
   assign fault_b_out_o               = 1'b0;
   assign fault_b_out_oe              = flt_b_q;
   assign secondary_supply_bad_out_o  = 1'b0;
   assign secondary_supply_bad_out_oe = uv_q;
   assign reset_ready_pin_o           = 1'b0;
   assign reset_ready_pin_oe          = ~rdy_q;

   // ----------------------------------------------------------------------
   // Serial pin gating
   // ----------------------------------------------------------------------
   // Combinational so the serial clock keeps its own edges downstream.
   // Data out is the shifter bit as is; the enable alone tristates it.
   assign serial_clk_gated   = serial_select_low ? 1'b1 : serial_clk_in;
   assign serial_data_gated  = serial_select_low ? 1'b1 : serial_data_in;
   assign serial_data_out_o  = serial_data_tx;
   assign serial_data_out_oe = ~serial_select_low;

endmodule

/* File: verification/gdpin_ctrl_assertions.sv */
/* Checker for gdpin_ctrl pin behaviour.
   Assumes it is bound to gdpin_ctrl on one clock. */
`timescale 1ns/1ps
module gdpin_ctrl_assertions
   import gdpin_pkg::*;
(
   input wire logic         core_clk,
   input wire logic         rstn,
   input wire logic         enable_in,
   input wire logic         pwm_cmd,
   input wire logic         output_stage_disable_in,
   input wire logic         reset_ready_pin_i,
   input wire logic         reset_ready_pin_oe,
   input wire logic         fault_a_out_oe,
   input wire logic         fault_b_out_oe,
   input wire logic         secondary_supply_bad_out_oe,
   input wire gdpin_mon_t   mon,
   input wire logic         miller_clamp_enable_out,
   input wire gdpin_stage_t stage,
   input wire logic         debug_mode,
   input wire logic         serial_select_low,
   input wire logic         serial_clk_gated,
   input wire logic         serial_data_out_oe,
   input wire gdpin_state_t state
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Six samples cover the three-stage sync plus agreement
   sequence held_off_s; !enable_in[*6]; endsequence
   sequence pin_low_s; !reset_ready_pin_i[*6]; endsequence
   fault_a_a: assert property ($past(rstn) |-> fault_a_out_oe == $past(mon.fail_class_a))
      else $error("fault a mismatch");
   fault_b_a: assert property (mon.fail_class_b || mon.reset_event |=> fault_b_out_oe)
      else $error("fault b not pulled");
   pin_reset_a: assert property (pin_low_s |=> state == GDPIN_ST_RESET && fault_b_out_oe)
      else $error("pin reset ignored");
   ready_a: assert property (!reset_ready_pin_oe |-> $past(mon.primary_ok))
      else $error("ready without primary ok");
   strap_a: assert property (debug_mode |=> debug_mode)
      else $error("debug mode lost");
   disable_a: assert property (output_stage_disable_in[*6] |=> !stage.on_oe && !stage.off_oe)
      else $error("stage driven while disabled");
   enable_a: assert property (held_off_s |=> state != GDPIN_ST_ON)
      else $error("on while enable low");
   on_a: assert property (state == GDPIN_ST_ON |-> $past(pwm_cmd))
      else $error("on without command");
   supply_a: assert property ($past(rstn) |->
      secondary_supply_bad_out_oe == $past(mon.sec_supply_lockout || mon.vreg_invalid))
      else $error("supply bad mismatch");
   clamp_a: assert property ($past(rstn) |-> miller_clamp_enable_out ==
      ($past(mon.gate_below_clamp) && $past(state) != GDPIN_ST_ON))
      else $error("clamp mismatch");
   serial_a: assert property (serial_select_low |-> serial_clk_gated && !serial_data_out_oe)
      else $error("serial active while deselected");
endmodule
bind gdpin_ctrl gdpin_ctrl_assertions gdpin_ctrl_assertions_inst (.*);

/* File: verification/gdpin_host_model.sv */
/* Host side of the pins: pull-ups on open-drain lines, reset pull, select.
   Assumes oe high means the device pulls the line low. */
`timescale 1ns/1ps
module gdpin_host_model (
   input  wire logic core_clk,
   input  wire logic host_reset_req,
   input  wire logic select_req,
   input  wire logic ready_oe,
   input  wire logic fa_oe,
   input  wire logic fb_oe,
   input  wire logic sb_oe,
   output logic      ready_lvl,
   output logic      fa_lvl,
   output logic      fb_lvl,
   output logic      sb_lvl,
   output logic      sel_n = 1'b1,
   output logic      sclk = 1'b1
);
   assign ready_lvl = !(ready_oe || host_reset_req);
   assign fa_lvl = !fa_oe;
   assign fb_lvl = !fb_oe;
   assign sb_lvl = !sb_oe;
   always_ff @(posedge core_clk) begin
      sel_n <= !select_req;
      // Clock stands high at the pull-up outside frames
      sclk <= sel_n ? 1'b1 : !sclk;
   end
endmodule

/* File: verification/test_gdpin_ctrl.sv */
/* Testbench for gdpin_ctrl: strap, random monitor and enable segments,
   pin reset. Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module test_gdpin_ctrl import gdpin_pkg::*; ;
   logic core_clk = 1'b0, rstn = 1'b0, enable_in = 1'b0, pwm_cmd = 1'b0, output_stage_disable_in = 1'b0;
   logic debug_strap_in = 1'b1, host_reset_req = 1'b0, select_req = 1'b0, sdi = 1'b1, sdt = 1'b0;
   logic ready_oe, fa_oe, fb_oe, sb_oe, ready_lvl, fa_lvl, fb_lvl, sb_lvl, sel_n, sclk, clk_g, sdo_oe, dbg, sd_g, sdo;
   logic [2:0] e;
   gdpin_mon_t mon = 7'h08, last;
   gdpin_stage_t stage;
   gdpin_state_t state;
   int fails = 0, samples_checked = 0;
   integer seed = 32'h9676;
   always #25 core_clk = ~core_clk;
   gdpin_host_model gdpin_host_model_inst (.core_clk(core_clk), .host_reset_req(host_reset_req),
      .select_req(select_req), .ready_oe(ready_oe), .fa_oe(fa_oe), .fb_oe(fb_oe), .sb_oe(sb_oe),
      .ready_lvl(ready_lvl), .fa_lvl(fa_lvl), .fb_lvl(fb_lvl), .sb_lvl(sb_lvl), .sel_n(sel_n), .sclk(sclk));
   gdpin_ctrl gdpin_ctrl_inst (.core_clk(core_clk), .rstn(rstn), .enable_in(enable_in), .pwm_cmd(pwm_cmd),
      .output_stage_disable_in(output_stage_disable_in), .debug_strap_in(debug_strap_in),
      .reset_ready_pin_i(ready_lvl), .reset_ready_pin_o(), .reset_ready_pin_oe(ready_oe),
      .fault_a_out_o(), .fault_a_out_oe(fa_oe), .fault_b_out_o(), .fault_b_out_oe(fb_oe),
      .secondary_supply_bad_out_o(), .secondary_supply_bad_out_oe(sb_oe), .mon(mon),
      .miller_clamp_enable_out(), .stage(stage), .debug_mode(dbg), .serial_select_low(sel_n),
      .serial_clk_in(sclk), .serial_data_in(sdi), .serial_data_tx(sdt), .serial_clk_gated(clk_g),
      .serial_data_gated(sd_g), .serial_data_out_o(sdo), .serial_data_out_oe(sdo_oe), .state(state));
   function automatic logic [2:0] exp_lv(input gdpin_mon_t m);
      return ~{m.fail_class_a, m.fail_class_b | m.reset_event, m.sec_supply_lockout | m.vreg_invalid};
   endfunction
   task automatic check_bit(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      if (fails == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (12) @(posedge core_clk);
      debug_strap_in <= 1'b0;
      repeat (10) @(negedge core_clk);
      check_bit("debug mode", 1'b1, dbg);
      check_bit("ready", 1'b1, ready_lvl);
      for (int s = 0; s < 40; s++) begin
         @(posedge core_clk);
         {enable_in, pwm_cmd, output_stage_disable_in, select_req} <= 4'($random(seed));
         last = mon;
         for (int c = 0; c < 8; c++) begin
            @(posedge core_clk);
            mon <= {3'($random(seed)), 1'b1, 3'($random(seed))};
            {sdi, sdt} <= 2'($random(seed));
            @(negedge core_clk);
            e = exp_lv(last);
            check_bit("fault a", e[2], fa_lvl);
            check_bit("fault b", e[1], fb_lvl);
            check_bit("supply bad", e[0], sb_lvl);
            if (sel_n) begin
               check_bit("serial out enable", 1'b0, sdo_oe | ~clk_g | ~sd_g);
            end else begin
               check_bit("serial pass", 1'b1, sdo_oe & (clk_g === sclk) & (sd_g === sdi) & (sdo === sdt));
            end
            last = mon;
         end
         if (output_stage_disable_in) check_bit("stage enable", 1'b0, stage.on_oe | stage.off_oe);
         check_bit("turned on", enable_in & pwm_cmd, state === GDPIN_ST_ON);
         if (!output_stage_disable_in) check_bit("stage enabled", 1'b1, stage.on_oe & stage.off_oe);
         check_bit("turn-on drive", enable_in & pwm_cmd, stage.on_drive);
         check_bit("turn-off drive", ~(enable_in & pwm_cmd), stage.off_drive);
      end
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge core_clk);
      debug_strap_in <= 1'b1;
      repeat (6) @(negedge core_clk);
      check_bit("debug mode after reset", 1'b0, dbg);
      check_bit("ready after reset", 1'b1, ready_lvl);
      check_bit("state after reset", 1'b0, state === GDPIN_ST_RESET);
      @(posedge core_clk);
      host_reset_req <= 1'b1;
      repeat (8) @(negedge core_clk);
      check_bit("pin reset state", 1'b1, state === GDPIN_ST_RESET);
      check_bit("fault b in reset", 1'b0, fb_lvl);
      print_verdict();
   end
   initial begin
      #100_000;
      fails++;
      print_verdict();
   end
endmodule
